// ===== verilog/pintc_top.sv
// prioritized interrupt controller with apb registers and core link
// Behaviour
// - arbitrate sources and traps by priority
// - 24-bit mux loads vector into pc
// - flags set by source, cleared by software
// - per-source enable bits in three registers
// - 4-bit cpu level, bit3 core control
// - ctrl1 trap flags, ctrl2 alt table
// - flags set regardless of enable
// - maskable levels 1 to 7
// - level zero never taken
// - nesting disable blocks new maskable interrupts while one is in service; traps still taken
// - cpu level read-only under nesting disable
// - trigger options live in peripherals
// - temporary disable blocks levels up to 6
// - pc loaded from vector location
// - 63 vectors at 0x000004 to 0x0000FE
// - vector fetch in normal flow traps
// - jump into vector space traps
// - 3-bit priority in low nibble bits
// - ties won by lowest interrupt number
// - traps use levels 11 to 14
module pintc_top #(
    parameter int NUM_SRC   = 43,
    parameter logic [47:0] SRC_MASK = 48'h067F_FFFF_FFFF
) (
    // apb slave
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // peripheral and trap events
    input  wire logic [NUM_SRC-1:0]        src_event,
    input  wire logic [pintc_pkg::NUM_TRAP-1:0] trap_event,
    // processor core link
    input  wire pintc_pkg::pintc_core_ctl_t core_ctl,
    input  wire pintc_pkg::pintc_core_pc_t  core_pc,
    output pintc_pkg::pintc_core_req_t      core_req,
    output logic      [23:0]               pc_in,
    output logic      [3:0]                cpu_level
);
    import pintc_pkg::*;

    logic [47:0]                flags_reg;
    logic [47:0]                enables_reg;
    logic [2:0]                 prio_reg [NUM_SRC];
    logic                       nest_dis_reg;
    logic [NUM_TRAP-1:0]        trap_flag_reg;
    logic                       alt_table_reg;
    logic [3:0]                 level_reg;
    logic [13:0]                temp_cnt_reg;
    logic [5:0]                 depth_reg;
    logic [31:0]                rdata_reg;
    logic [23:0]                pc_in_reg;
    pintc_core_req_t            req_reg;
    pintc_core_req_t            req_next;

    logic                       wr_en;
    logic                       rd_setup;
    logic                       mapped;
    logic [31:0]                rdata_next;
    logic [47:0]                src_wide;
    logic [NUM_TRAP-1:0]        trap_set;
    logic                       addr_err;
    logic                       temp_dis;

    assign wr_en    = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = rdata_reg;
    assign core_req = req_reg;
    assign pc_in    = pc_in_reg;
    assign cpu_level = level_reg;
    assign temp_dis = temp_cnt_reg != 14'h0000;

    always_comb begin
        mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS);
    end

    always_comb begin
        src_wide = '0;
        src_wide[NUM_SRC-1:0] = src_event;
        src_wide = src_wide & SRC_MASK;
    end

    always_comb begin
        addr_err = (core_pc.fetch_valid && !core_pc.fetch_is_vector
                    && core_pc.fetch_addr >= VEC_SPACE_LO && core_pc.fetch_addr <= VEC_SPACE_HI)
                || (core_pc.jump_valid
                    && core_pc.jump_target >= VEC_SPACE_LO && core_pc.jump_target <= VEC_SPACE_HI);
        trap_set = trap_event;
        trap_set[TRAP_ADDR_ERR] = trap_event[TRAP_ADDR_ERR] || addr_err;
    end

    // set by source, cleared by write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= '0;
        end else begin
            for (int r = 0; r < 3; r++) begin
                if (wr_en && paddr == OFS_FLAGS_0 + 12'(4 * r)) begin
                    flags_reg[16*r +: 16] <= (flags_reg[16*r +: 16] & pwdata[15:0]) | src_wide[16*r +: 16];
                end else begin
                    flags_reg[16*r +: 16] <= flags_reg[16*r +: 16] | src_wide[16*r +: 16];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enables_reg <= '0;
        end else begin
            for (int r = 0; r < 3; r++) begin
                if (wr_en && paddr == OFS_ENABLES_0 + 12'(4 * r)) begin
                    enables_reg[16*r +: 16] <= pwdata[15:0] & SRC_MASK[16*r +: 16];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                prio_reg[i] <= 3'h0;
            end
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (wr_en && paddr == OFS_PRIO_FIRST + 12'(4 * (i / 4))) begin
                    prio_reg[i] <= pwdata[4*(i%4) +: 3];
                end
            end
        end
    end

    // global control one: nesting and trap flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nest_dis_reg  <= 1'b0;
            trap_flag_reg <= '0;
        end else begin
            if (wr_en && paddr == OFS_GCTRL_1) begin
                nest_dis_reg  <= pwdata[BIT_NEST_DIS];
                trap_flag_reg <= (trap_flag_reg & pwdata[NUM_TRAP-1:0]) | trap_set;
            end else begin
                trap_flag_reg <= trap_flag_reg | trap_set;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_table_reg <= 1'b0;
        end else if (wr_en && paddr == OFS_GCTRL_2) begin
            alt_table_reg <= pwdata[BIT_ALT_TABLE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_cnt_reg <= 14'h0000;
        end else if (core_ctl.temp_dis_start) begin
            temp_cnt_reg <= core_ctl.temp_dis_count;
        end else if (core_ctl.retire && temp_dis) begin
            temp_cnt_reg <= temp_cnt_reg - 14'h0001;
        end
    end

    // cpu level, raised on take, restored on return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_reg <= RST_LEVEL;
        end else if (core_ctl.ack && req_reg.valid) begin
            level_reg <= req_reg.level;
        end else if (core_ctl.ret) begin
            level_reg <= core_ctl.ret_level;
        end else if (wr_en && paddr == OFS_CPU_LEVEL && !nest_dis_reg) begin
            level_reg <= pwdata[3:0];
        end
    end

    // service nesting depth
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_reg <= 6'h00;
        end else if (core_ctl.ack && req_reg.valid && !core_ctl.ret) begin
            depth_reg <= depth_reg + 6'h01;
        end else if (core_ctl.ret && !(core_ctl.ack && req_reg.valid) && depth_reg != 6'h00) begin
            depth_reg <= depth_reg - 6'h01;
        end
    end

    always_comb begin
        logic [3:0] best_lvl;
        logic [5:0] best_vec;
        logic [3:0] lvl;
        logic       found;
        best_lvl = 4'h0;
        best_vec = 6'h00;
        lvl      = 4'h0;
        found    = 1'b0;
        // downward scan lets lower number win ties
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            lvl = {1'b0, prio_reg[i]};
            if (flags_reg[i] && enables_reg[i] && lvl != 4'h0 && lvl > level_reg
                && lvl >= best_lvl
                && !(temp_dis && lvl <= LVL_TEMP_DIS_MAX)
                && !(nest_dis_reg && depth_reg != 6'h00)) begin
                best_lvl = lvl;
                best_vec = IRQ_VEC_OFFSET + 6'(i);
                found    = 1'b1;
            end
        end
        // traps at fixed levels above maskable
        for (int t = NUM_TRAP - 1; t >= 0; t--) begin
            if (trap_flag_reg[t] && TRAP_LEVEL[t] > level_reg && TRAP_LEVEL[t] >= best_lvl) begin
                best_lvl = TRAP_LEVEL[t];
                best_vec = TRAP_VEC[t];
                found    = 1'b1;
            end
        end
        req_next.valid  = found;
        req_next.level  = best_lvl;
        req_next.vector = best_vec;
        req_next.location = (alt_table_reg ? ALTERNATE_VECTOR_TABLE_BASE : IVT_BASE) + {17'h0_0000, best_vec, 1'b0};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg <= '0;
        end else if (core_ctl.ack && req_reg.valid) begin
            req_reg <= '0;
        end else begin
            req_reg <= req_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_in_reg <= 24'h000000;
        end else if (core_pc.vector_load) begin
            pc_in_reg <= core_pc.prog_data;
        end else begin
            pc_in_reg <= core_pc.pc_seq;
        end
    end

    // register read data, captured in setup phase
    always_comb begin
        rdata_next = 32'h0000_0000;
        for (int r = 0; r < 3; r++) begin
            if (paddr == OFS_FLAGS_0 + 12'(4 * r)) begin
                rdata_next[15:0] = flags_reg[16*r +: 16];
            end
            if (paddr == OFS_ENABLES_0 + 12'(4 * r)) begin
                rdata_next[15:0] = enables_reg[16*r +: 16];
            end
        end
        for (int i = 0; i < NUM_SRC; i++) begin
            if (paddr == OFS_PRIO_FIRST + 12'(4 * (i / 4))) begin
                rdata_next[4*(i%4) +: 3] = prio_reg[i];
            end
        end
        if (paddr == OFS_GCTRL_1) begin
            rdata_next[BIT_NEST_DIS]   = nest_dis_reg;
            rdata_next[NUM_TRAP-1:0]   = trap_flag_reg;
        end
        if (paddr == OFS_GCTRL_2) begin
            rdata_next[BIT_ALT_TABLE]  = alt_table_reg;
            rdata_next[BIT_TEMP_DIS]   = temp_dis;
        end
        if (paddr == OFS_CPU_LEVEL) begin
            rdata_next[3:0] = level_reg;
        end
        if (paddr == OFS_STATUS) begin
            rdata_next[0]     = req_reg.valid;
            rdata_next[7:4]   = req_reg.level;
            rdata_next[13:8]  = req_reg.vector;
            rdata_next[21:16] = depth_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            rdata_reg <= rdata_next;
        end
    end

endmodule

// ===== verilog/pintc_pkg.sv
// package: register map, field layout, core link structs for the interrupt controller
package pintc_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_FLAGS_0      = 12'h000;
    localparam logic [11:0] OFS_FLAGS_1      = 12'h004;
    localparam logic [11:0] OFS_FLAGS_2      = 12'h008;
    localparam logic [11:0] OFS_ENABLES_0    = 12'h00C;
    localparam logic [11:0] OFS_ENABLES_1    = 12'h010;
    localparam logic [11:0] OFS_ENABLES_2    = 12'h014;
    localparam logic [11:0] OFS_GCTRL_1      = 12'h018;
    localparam logic [11:0] OFS_GCTRL_2      = 12'h01C;
    localparam logic [11:0] OFS_PRIO_FIRST   = 12'h020;
    localparam logic [11:0] OFS_PRIO_LAST    = 12'h048;
    localparam logic [11:0] OFS_CPU_LEVEL    = 12'h04C;
    localparam logic [11:0] OFS_STATUS       = 12'h050;

    // field positions
    localparam int BIT_NEST_DIS   = 15;
    localparam int BIT_TEMP_DIS   = 14;
    localparam int BIT_ALT_TABLE  = 15;
    localparam int BIT_CORE_LVL3  = 3;

    // reset values
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [3:0]  RST_LEVEL  = 4'h0;

    // priority and vector constants
    localparam logic [3:0]  LVL_TEMP_DIS_MAX = 4'h6;
    localparam logic [5:0]  IRQ_VEC_OFFSET   = 6'h08;
    localparam logic [23:0] IVT_BASE         = 24'h000004;
    localparam logic [23:0] ALTERNATE_VECTOR_TABLE_BASE        = 24'h000084;
    localparam logic [23:0] VEC_SPACE_LO     = 24'h000004;
    localparam logic [23:0] VEC_SPACE_HI     = 24'h0000FE;

    // traps: oscillator fail, address error, stack error, math error
    localparam int          NUM_TRAP         = 4;
    localparam int          TRAP_ADDR_ERR    = 1;
    localparam logic [3:0]  TRAP_LEVEL [NUM_TRAP] = '{4'hE, 4'hD, 4'hC, 4'hB};
    localparam logic [5:0]  TRAP_VEC   [NUM_TRAP] = '{6'h01, 6'h02, 6'h03, 6'h04};

    typedef struct packed {
        logic        valid;
        logic [3:0]  level;
        logic [5:0]  vector;
        logic [23:0] location;
    } pintc_core_req_t;

    typedef struct packed {
        logic        ack;
        logic        ret;
        logic [3:0]  ret_level;
        logic        retire;
        logic        temp_dis_start;
        logic [13:0] temp_dis_count;
    } pintc_core_ctl_t;

    typedef struct packed {
        logic        fetch_valid;
        logic [23:0] fetch_addr;
        logic        fetch_is_vector;
        logic        jump_valid;
        logic [23:0] jump_target;
        logic        vector_load;
        logic [23:0] prog_data;
        logic [23:0] pc_seq;
    } pintc_core_pc_t;

endpackage

// ===== verif/pintc_props.sv
// checker: timing relations at the controller top ports
module pintc_props #(
    parameter int NUM_SRC = 43
) (
    // apb slave
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [11:0]                paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    // events
    input wire logic [NUM_SRC-1:0]         src_event,
    input wire logic [3:0]                 trap_event,
    // core link
    input wire pintc_pkg::pintc_core_ctl_t core_ctl,
    input wire pintc_pkg::pintc_core_pc_t  core_pc,
    input wire pintc_pkg::pintc_core_req_t core_req,
    input wire logic [23:0]                pc_in,
    input wire logic [3:0]                 cpu_level
);
    timeunit 1ns;
    timeprecision 1ns;
    import pintc_pkg::*;
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    function automatic logic in_vec(logic [23:0] a);
        return a >= VEC_SPACE_LO && a <= VEC_SPACE_HI;
    endfunction
    a_pc_vec_load:
        assert property (core_pc.vector_load |=> pc_in == $past(core_pc.prog_data))
        else $error("pc input missed program data");
    a_pc_seq_path:
        assert property (!core_pc.vector_load |=> pc_in == $past(core_pc.pc_seq))
        else $error("pc input missed sequential address");
    a_jump_trap:
        assert property (core_pc.jump_valid && in_vec(core_pc.jump_target) && cpu_level < 4'hD
            |-> ##[2:4] core_req.valid && core_req.vector == 6'h02)
        else $error("jump into vector space not trapped");
    a_fetch_trap:
        assert property (core_pc.fetch_valid && !core_pc.fetch_is_vector && in_vec(core_pc.fetch_addr)
            && cpu_level < 4'hD |-> ##[2:4] core_req.valid && core_req.vector == 6'h02)
        else $error("vector word fetch not trapped");
    a_trap_level:
        assert property (core_req.valid && core_req.vector < 6'h08 |-> core_req.level[3])
        else $error("trap request below level eight");
    a_above_level:
        assert property (core_req.valid |-> core_req.level > $past(cpu_level))
        else $error("request not above cpu level");
    a_vec_location:
        assert property (core_req.valid |-> core_req.location <= 24'h0000FE
            && core_req.location[0] == 1'b0 && core_req.location >= 24'h000004)
        else $error("vector location outside table");
    a_irq_range:
        assert property (core_req.valid && !core_req.level[3] |-> core_req.level != 4'h0
            && core_req.vector >= 6'h08 && core_req.vector <= 6'h32)
        else $error("maskable request out of range");
    a_ack_raise:
        assert property (core_ctl.ack && core_req.valid |=> !core_req.valid
            && cpu_level == $past(core_req.level))
        else $error("acknowledge did not raise level");
    c_trap: cover property (core_req.valid && core_req.level[3]);
    c_ack: cover property (core_ctl.ack && core_req.valid);
    c_load: cover property (core_pc.vector_load);
endmodule

bind pintc_top pintc_props #(.NUM_SRC(NUM_SRC)) i_pintc_props (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .src_event, .trap_event, .core_ctl, .core_pc, .core_req,
    .pc_in, .cpu_level);

// ===== verif/pintc_core_model.sv
// processor core model: takes requests, returns, retires instructions
module pintc_core_model (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // bench controls
    input  wire logic                        ret_go,
    input  wire logic                        dis_go,
    input  wire logic                        run,
    // controller link
    input  wire pintc_pkg::pintc_core_req_t  core_req,
    output pintc_pkg::pintc_core_ctl_t       core_ctl
);
    timeunit 1ns;
    timeprecision 1ns;
    import pintc_pkg::*;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ctl <= '0;
        end else begin
            core_ctl.ack <= core_req.valid && !core_ctl.ack;
            core_ctl.ret <= ret_go;
            core_ctl.ret_level <= 4'h0;
            core_ctl.retire <= run;
            core_ctl.temp_dis_start <= dis_go;
            core_ctl.temp_dis_count <= 14'h0004;
        end
    end
endmodule

// ===== verif/test_prioritized_interrupt_controller.sv
// testbench: register and core link scenarios for the interrupt controller
module test_prioritized_interrupt_controller;
    timeunit 1ns;
    timeprecision 1ns;
    import pintc_pkg::*;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic            ret_go, dis_go, run, seen_req, rerr;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rdat;
    logic [42:0]     src_event;
    logic [3:0]      trap_event, cpu_level;
    logic [23:0]     pc_in, vbase;
    pintc_core_ctl_t core_ctl;
    pintc_core_pc_t  core_pc;
    pintc_core_req_t core_req, q;
    int              n_mismatch, n_tests;
    pintc_top i_pintc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .src_event, .trap_event, .core_ctl, .core_pc, .core_req, .pc_in, .cpu_level);
    pintc_core_model i_pintc_core_model (.pclk, .presetn, .ret_go, .dis_go, .run, .core_req, .core_ctl);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(negedge pclk) if (core_req.valid === 1'b1) seen_req = 1'b1;
    task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [15:0] e);
        apb(1'b0, a, 16'h0000);
        chk(nm, rdat, {16'h0000, e});
    endtask
    task automatic req_chk(input logic [3:0] l, input logic [5:0] v);
        int n;
        n = 0;
        q = '0;
        while (q.valid !== 1'b1 && n < 50) begin
            @(negedge pclk);
            q = core_req;
            n++;
        end
        chk("request", q, {1'b1, l, v, vbase + {17'h0, v, 1'b0}});
    endtask
    task automatic ev(input logic [42:0] m);
        @(posedge pclk);
        src_event <= m;
        @(posedge pclk);
        src_event <= '0;
    endtask
    task automatic retn(input int n);
        @(posedge pclk);
        ret_go <= 1'b1;
        repeat (n) @(posedge pclk);
        ret_go <= 1'b0;
    endtask
    task automatic quiet(input string nm);
        seen_req = 1'b0;
        repeat (8) @(posedge pclk);
        chk(nm, seen_req, 1'b0);
    endtask
    task automatic pcev(input logic j, input logic [23:0] a);
        @(posedge pclk);
        core_pc.jump_valid <= j;
        core_pc.fetch_valid <= !j;
        core_pc.jump_target <= a;
        core_pc.fetch_addr <= a;
        @(posedge pclk);
        core_pc.jump_valid <= 1'b0;
        core_pc.fetch_valid <= 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ret_go, dis_go, run} = '0;
        {src_event, trap_event, core_pc, seen_req} = '0;
        vbase = IVT_BASE;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) rdc("reset", 12'(4 * i), 16'h0000);
        rdc("unmapped", 12'h054, 16'h0000);
        chk("slverr", rerr, 1'b1);
        ev(43'h8);
        rdc("flag", OFS_FLAGS_0, 16'h0008);
        apb(1'b1, OFS_FLAGS_0, 16'h0000);
        rdc("flag clear", OFS_FLAGS_0, 16'h0000);
        ev(43'h7FF_0000_0000);
        rdc("flags high", OFS_FLAGS_2, 16'h067F);
        apb(1'b1, OFS_FLAGS_2, 16'h0000);
        apb(1'b1, OFS_ENABLES_2, 16'hFFFF);
        rdc("enables high", OFS_ENABLES_2, 16'h067F);
        apb(1'b1, OFS_ENABLES_2, 16'h0000);
        apb(1'b1, OFS_PRIO_FIRST, 16'hD000);
        rdc("prio", OFS_PRIO_FIRST, 16'h5000);
        apb(1'b1, OFS_ENABLES_0, 16'h0008);
        ev(43'h8);
        req_chk(4'h5, 6'h0B);
        repeat (3) @(posedge pclk);
        chk("level", cpu_level, 4'h5);
        apb(1'b1, OFS_FLAGS_0, 16'h0000);
        retn(1);
        apb(1'b1, OFS_PRIO_FIRST, 16'h5330);
        apb(1'b1, OFS_ENABLES_0, 16'h0007);
        ev(43'h7);
        req_chk(4'h3, 6'h09);
        apb(1'b1, OFS_FLAGS_0, 16'h0000);
        retn(1);
        ev(43'h1);
        quiet("zero prio");
        apb(1'b1, OFS_PRIO_FIRST, 16'h5070);
        apb(1'b1, OFS_ENABLES_0, 16'h000A);
        apb(1'b1, OFS_GCTRL_1, 16'h8000);
        ev(43'h8);
        req_chk(4'h5, 6'h0B);
        apb(1'b1, OFS_CPU_LEVEL, 16'h0002);
        rdc("level ro", OFS_CPU_LEVEL, 16'h0005);
        ev(43'h2);
        quiet("nesting");
        apb(1'b1, OFS_GCTRL_1, 16'h0000);
        req_chk(4'h7, 6'h09);
        apb(1'b1, OFS_FLAGS_0, 16'h0000);
        retn(2);
        apb(1'b1, OFS_PRIO_FIRST, 16'h6000);
        @(posedge pclk);
        dis_go <= 1'b1;
        @(posedge pclk);
        dis_go <= 1'b0;
        rdc("disable bit", OFS_GCTRL_2, 16'h4000);
        ev(43'h8);
        quiet("disable");
        run <= 1'b1;
        req_chk(4'h6, 6'h0B);
        rdc("disable end", OFS_GCTRL_2, 16'h0000);
        apb(1'b1, OFS_FLAGS_0, 16'h0000);
        retn(1);
        pcev(1'b1, 24'h000020);
        req_chk(4'hD, 6'h02);
        rdc("trap flag", OFS_GCTRL_1, 16'h0002);
        apb(1'b1, OFS_GCTRL_1, 16'h0000);
        retn(1);
        pcev(1'b0, 24'h0000FE);
        req_chk(4'hD, 6'h02);
        apb(1'b1, OFS_GCTRL_1, 16'h0000);
        retn(1);
        core_pc.fetch_is_vector <= 1'b1;
        pcev(1'b0, 24'h00001A);
        quiet("vector fetch");
        core_pc.fetch_is_vector <= 1'b0;
        @(posedge pclk);
        trap_event <= 4'hC;
        @(posedge pclk);
        trap_event <= 4'h0;
        req_chk(4'hC, 6'h03);
        rdc("trap flags", OFS_GCTRL_1, 16'h000C);
        apb(1'b1, OFS_GCTRL_1, 16'h0000);
        retn(1);
        apb(1'b1, OFS_GCTRL_2, 16'h8000);
        rdc("alt table", OFS_GCTRL_2, 16'h8000);
        vbase = ALTERNATE_VECTOR_TABLE_BASE;
        ev(43'h8);
        req_chk(4'h6, 6'h0B);
        apb(1'b1, OFS_FLAGS_0, 16'h0000);
        retn(1);
        apb(1'b1, OFS_GCTRL_2, 16'h0000);
        @(posedge pclk);
        core_pc.vector_load <= 1'b1;
        core_pc.prog_data <= 24'hABCDEF;
        @(posedge pclk);
        core_pc.vector_load <= 1'b0;
        core_pc.pc_seq <= 24'h000200;
        @(negedge pclk);
        chk("pc load", pc_in, 24'hABCDEF);
        @(posedge pclk);
        @(negedge pclk);
        chk("pc seq", pc_in, 24'h000200);
        stop_test();
    end
endmodule
